// ==== pio_pkg.sv ====
package pio_pkg;
   // ------------------------------------------------------------
   // register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_DATA = 8'h00;
   localparam logic [7:0] OFF_DIR = 8'h04;
   localparam logic [7:0] OFF_PULL = 8'h08;
   localparam logic [7:0] OFF_SLEW = 8'h0C;
   localparam logic [7:0] OFF_DRIVE = 8'h10;
   localparam logic [7:0] OFF_ANALOG = 8'h14;
   localparam logic [7:0] OFF_PWR = 8'h18;
   // ------------------------------------------------------------
   // power register fields and reset values
   // ------------------------------------------------------------
   localparam int PWR_FLAG_BIT = 3;
   localparam int PWR_ACK_BIT = 2;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam int SYNC_STAGES = 2;
   // ------------------------------------------------------------
   // bus constants
   // ------------------------------------------------------------
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage

// ==== pio_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module pio_sync
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [7:0] d_in,
   output logic [7:0] q_out
);
   // ------------------------------------------------------------
   // two-stage synchroniser per pin
   // ------------------------------------------------------------
   logic [7:0] meta_reg;
   logic [7:0] sync_reg;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         meta_reg <= pio_pkg::RST_BYTE;
         sync_reg <= pio_pkg::RST_BYTE;
      end
      else
      begin
         meta_reg <= d_in;
         sync_reg <= meta_reg;
      end
   end
   assign q_out = sync_reg;
endmodule
`default_nettype wire

// ==== pio_port.sv ====
// Overview of operation
// - direction 0 disables driver, reads pin
// - direction 1 drives, reads latch
// - direction bit selects read under override
// - analog disables digital, reads zero
// - analog wins over alternate function
// - pin control independent of data/direction
// - pullup off whenever pin is output
// - pullup off under analog control
// - slew limit only on outputs
// - drive boost selects high drive
// - deep stop holds pin latches
// - light stop keeps all state
// - data write updates all eight bits
// - reset clears latch, pins input
// - direction bits readable and writable
// - acknowledge write clears powerdown flag
// - reset leaves all pin controls off except analog_on, which follows analog_req
`timescale 1ns/1ps
`default_nettype none
module pio_port
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe,
   output logic [7:0] pull_on,
   output logic [7:0] slew_on,
   output logic [7:0] drive_high,
   output logic [7:0] analog_on,
   input wire logic [7:0] periph_own,
   input wire logic [7:0] periph_oe,
   input wire logic [7:0] periph_out,
   input wire logic [7:0] analog_req,
   input wire logic deep_stop,
   input wire logic deep_wake
);
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   logic [7:0] data_reg;
   logic [7:0] dir_reg;
   logic [7:0] pull_reg;
   logic [7:0] slew_reg;
   logic [7:0] drive_reg;
   logic [7:0] analog_reg;
   logic flag_reg;
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic [31:0] rdata_reg;
   logic [7:0] pin_sync;
   logic [7:0] pin_out_reg;
   logic [7:0] pin_oe_reg;
   logic [7:0] pull_on_reg;
   logic [7:0] slew_on_reg;
   logic [7:0] drive_on_reg;
   // ------------------------------------------------------------
   // input synchroniser
   // ------------------------------------------------------------
   // synchronised pin levels
   pio_sync u_sync
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .d_in(pin_in),
      .q_out(pin_sync)
   );
   // ------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction
   wire addr_ok = hsel && hready && htrans[1];
   wire wr_start = addr_ok && hwrite;
   wire rd_start = addr_ok && !hwrite;
   wire [7:0] aoff = haddr[7:0];
   wire [7:0] wb = hwdata[7:0];
   wire w_data = wr_pend_reg && hit(wr_addr_reg, pio_pkg::OFF_DATA);
   wire w_dir = wr_pend_reg && hit(wr_addr_reg, pio_pkg::OFF_DIR);
   wire w_pull = wr_pend_reg && hit(wr_addr_reg, pio_pkg::OFF_PULL);
   wire w_slew = wr_pend_reg && hit(wr_addr_reg, pio_pkg::OFF_SLEW);
   wire w_drive = wr_pend_reg && hit(wr_addr_reg, pio_pkg::OFF_DRIVE);
   wire w_ana = wr_pend_reg && hit(wr_addr_reg, pio_pkg::OFF_ANALOG);
   wire w_pwr = wr_pend_reg && hit(wr_addr_reg, pio_pkg::OFF_PWR);
   wire wr_allow = !deep_stop;
   // ------------------------------------------------------------
   // pin function resolution
   // ------------------------------------------------------------
   // analog wins over alternate function
   wire [7:0] ana = analog_reg | analog_req;
   wire [7:0] own = periph_own & ~ana;
   wire [7:0] oe_next = ~ana & ((own & periph_oe) | (~own & dir_reg));
   wire [7:0] out_next = (own & periph_out) | (~own & data_reg);
   wire [7:0] pull_next = pull_reg & ~oe_next & ~ana;
   wire [7:0] slew_next = slew_reg & oe_next;
   wire [7:0] drive_next = drive_reg & ~ana;
   wire [7:0] data_rd = ((dir_reg & data_reg) | (~dir_reg & pin_sync)) & ~ana;
   wire [7:0] pwr_rd = {7'h00, flag_reg} << pio_pkg::PWR_FLAG_BIT;
   wire [7:0] rd_next =
      hit(aoff, pio_pkg::OFF_DATA) ? data_rd :
      hit(aoff, pio_pkg::OFF_DIR) ? dir_reg :
      hit(aoff, pio_pkg::OFF_PULL) ? pull_reg :
      hit(aoff, pio_pkg::OFF_SLEW) ? slew_reg :
      hit(aoff, pio_pkg::OFF_DRIVE) ? drive_reg :
      hit(aoff, pio_pkg::OFF_ANALOG) ? analog_reg :
      hit(aoff, pio_pkg::OFF_PWR) ? pwr_rd : pio_pkg::RST_BYTE;
   // ------------------------------------------------------------
   // bus phase tracking
   // ------------------------------------------------------------
   // address phase capture, read data registered
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= pio_pkg::RST_BYTE;
         rdata_reg <= pio_pkg::ZERO_WORD;
      end
      else
      begin
         wr_pend_reg <= wr_start;
         wr_addr_reg <= aoff;
         if (rd_start)
         begin
            rdata_reg <= {24'h00_0000, rd_next};
         end
      end
   end
   // ------------------------------------------------------------
   // port registers
   // ------------------------------------------------------------
   // reset clears latch and direction
   // each group has its own write
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         data_reg <= pio_pkg::RST_BYTE;
         dir_reg <= pio_pkg::RST_BYTE;
         pull_reg <= pio_pkg::RST_BYTE;
         slew_reg <= pio_pkg::RST_BYTE;
         drive_reg <= pio_pkg::RST_BYTE;
         analog_reg <= pio_pkg::RST_BYTE;
      end
      else if (wr_allow)
      begin
         if (w_data)
            data_reg <= wb;
         if (w_dir)
            dir_reg <= wb;
         if (w_pull)
            pull_reg <= wb;
         if (w_slew)
            slew_reg <= wb;
         if (w_drive)
            drive_reg <= wb;
         if (w_ana)
            analog_reg <= wb;
      end
   end
   // ------------------------------------------------------------
   // partial power-down flag
   // ------------------------------------------------------------
   // wake sets, ack clears, set wins
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         flag_reg <= 1'b0;
      else if (deep_wake)
         flag_reg <= 1'b1;
      else if (w_pwr && wb[pio_pkg::PWR_ACK_BIT])
         flag_reg <= 1'b0;
   end
   // ------------------------------------------------------------
   // pin output registers
   // ------------------------------------------------------------
   // pin state held during deep stop
   // light stop needs no special path
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         pin_out_reg <= pio_pkg::RST_BYTE;
         pin_oe_reg <= pio_pkg::RST_BYTE;
         pull_on_reg <= pio_pkg::RST_BYTE;
         slew_on_reg <= pio_pkg::RST_BYTE;
         drive_on_reg <= pio_pkg::RST_BYTE;
      end
      else if (!deep_stop)
      begin
         pin_out_reg <= out_next;
         pin_oe_reg <= oe_next;
         pull_on_reg <= pull_next;
         slew_on_reg <= slew_next;
         drive_on_reg <= drive_next;
      end
   end
   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign pin_out = pin_out_reg;
   assign pin_oe = pin_oe_reg;
   assign pull_on = pull_on_reg;
   assign slew_on = slew_on_reg;
   assign drive_high = drive_on_reg;
   assign analog_on = ana;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_reg;
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   oe_follows_dir_a:
      assert property (@(posedge hclk) disable iff (!hresetn)
         (!deep_stop && periph_own == 8'h00 && ana == 8'h00)
         |=> pin_oe == $past(dir_reg))
      else $error("driver enable does not follow direction");
   pull_off_out_a:
      assert property (@(posedge hclk) disable iff (!hresetn)
         (pull_on & pin_oe) == 8'h00)
      else $error("pullup on while driving");
   ana_read_zero_a:
      assert property (@(posedge hclk) disable iff (!hresetn)
         rd_start |=> (hrdata[7:0] & $past(ana)) == 8'h00 ||
         !$past(hit(aoff, pio_pkg::OFF_DATA)))
      else $error("analog bit read non-zero");
   ana_no_drive_a:
      assert property (@(posedge hclk) disable iff (!hresetn)
         (!deep_stop && ana != 8'h00) |=> (pin_oe & $past(ana)) == 8'h00)
      else $error("analog pin still driven");
   data_write_a:
      assert property (@(posedge hclk) disable iff (!hresetn)
         (w_data && wr_allow) |=> data_reg == $past(wb))
      else $error("data latch not updated");
   dir_read_latch_a:
      assert property (@(posedge hclk) disable iff (!hresetn)
         (rd_start && hit(aoff, pio_pkg::OFF_DATA) && ana == 8'h00)
         |=> (hrdata[7:0] & $past(dir_reg)) ==
            ($past(data_reg) & $past(dir_reg)))
      else $error("output pin read not from latch");
   flag_clear_a:
      assert property (@(posedge hclk) disable iff (!hresetn)
         (w_pwr && wb[pio_pkg::PWR_ACK_BIT] && !deep_wake) |=> !flag_reg)
      else $error("acknowledge did not clear flag");
   flag_set_a:
      assert property (@(posedge hclk) disable iff (!hresetn)
         deep_wake |=> flag_reg)
      else $error("wake did not set flag");
   hold_stop_a:
      assert property (@(posedge hclk) disable iff (!hresetn)
         deep_stop |=> $stable(pin_out) && $stable(pin_oe))
      else $error("pins changed in deep stop");
   slew_input_a:
      assert property (@(posedge hclk) disable iff (!hresetn)
         (slew_on & ~pin_oe) == 8'h00)
      else $error("slew limit on an input");
   pull_off_ana_a:
      assert property (@(posedge hclk) disable iff (!hresetn)
         (!deep_stop && ana != 8'h00) |=> (pull_on & $past(ana)) == 8'h00)
      else $error("pullup on under analog control");
   drive_sel_a:
      assert property (@(posedge hclk) disable iff (!hresetn)
         !deep_stop |=>
            drive_high == ($past(drive_reg) & ~$past(ana)))
      else $error("drive strength does not follow select");
   dir_write_a:
      assert property (@(posedge hclk) disable iff (!hresetn)
         (w_dir && wr_allow) |=> dir_reg == $past(wb))
      else $error("direction not updated");
   ctrl_apart_a:
      assert property (@(posedge hclk) disable iff (!hresetn)
         (w_data || w_dir) |=> $stable(pull_reg) && $stable(slew_reg) &&
            $stable(drive_reg))
      else $error("data write changed pin control");
   sync_delay_a:
      assert property (@(posedge hclk) disable iff (!hresetn)
         $past(hresetn, 2) |-> pin_sync == $past(pin_in, 2))
      else $error("pin level not two cycles late");
endmodule
`default_nettype wire

// ==== pio_pins.sv ====
`timescale 1ns/1ps
`default_nettype none
// outside pads: a driven pin shows the port level
module pio_pins
(
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   input wire logic [7:0] ext_level,
   output logic [7:0] pin_in
);
   // undriven pins follow the outside source
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rd_ph;
   logic deep_stop, deep_wake;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata;
   logic [7:0] pin_in, pin_out, pin_oe, pull_on, slew_on, drive_high;
   logic [7:0] analog_on, own, poe, pout, areq, ext;
   logic [7:0] dreg, dir, pull, slew, drv, an, anl, eoe, eout;
   logic [31:0] exp_q[$];
   int n_mismatch, tests_run, k;
   pio_port pio_port_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .pull_on(pull_on), .slew_on(slew_on),
      .drive_high(drive_high), .analog_on(analog_on), .periph_own(own),
      .periph_oe(poe), .periph_out(pout), .analog_req(areq),
      .deep_stop(deep_stop), .deep_wake(deep_wake));
   pio_pins pio_pins_i (.pin_out(pin_out), .pin_oe(pin_oe),
      .ext_level(ext), .pin_in(pin_in));
   // expected pad state
   assign anl = an | areq;
   assign eoe = ~anl & ((own & poe) | (~own & dir));
   assign eout = (own & pout) | (~own & dreg);
   // clock
   initial
   begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   // ------------------------------------------------------------
   // checking and bus tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] want,
      input string what);
      tests_run++;
      if (seen !== want)
      begin
         n_mismatch++;
         $display("wrong value %s: expected %h, seen %h", what, want, seen);
      end
   endtask
   task automatic print_verdict;
      $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic wait_ready;
      k = 0;
      do
      begin
         @(posedge hclk);
         k++;
      end
      while (hreadyout !== 1'b1 && k < 50);
      if (hreadyout !== 1'b1)
      begin
         n_mismatch++;
         print_verdict();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= pio_pkg::HTRANS_NONSEQ;
      haddr <= 32'(a);
      hwrite <= w;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= d;
      rd_ph <= ~w;
      wait_ready();
      rd_ph <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] want);
      exp_q.push_back(want);
      bus(1'b0, a, pio_pkg::ZERO_WORD);
   endtask
   task automatic settle;
      repeat (4) @(posedge hclk);
   endtask
   function automatic logic [31:0] exp_data();
      logic [7:0] pin;
      pin = (eoe & eout) | (~eoe & ext);
      return 32'(~anl & ((dir & dreg) | (~dir & pin)));
   endfunction
   task automatic pads;
      check(32'(pin_oe), 32'(eoe), "pin_oe");
      check(32'(pin_out & eoe), 32'(eout & eoe), "pin_out");
      check(32'(pull_on), 32'(pull & ~eoe & ~anl), "pull_on");
      check(32'(slew_on), 32'(slew & eoe), "slew_on");
      check(32'(analog_on), 32'(anl), "analog_on");
      check(32'(drive_high & ~anl), 32'(drv & ~anl), "drive");
   endtask
   // read data monitor
   always @(posedge hclk)
      if (rd_ph && hreadyout === 1'b1)
         check(hrdata, exp_q.pop_front(), "hrdata");
   // watchdog
   initial
   begin
      #200000;
      n_mismatch++;
      print_verdict();
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      hresetn = 1'b0;
      {hsel, hwrite, rd_ph, deep_stop, deep_wake} = '0;
      {own, poe, pout, areq, ext, dreg, dir, pull, slew, drv, an} = '0;
      {htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      n_mismatch = 0;
      tests_run = 0;
      void'($urandom(63));
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int i = 0; i < 8; i++)
         rd(8'(4 * i), pio_pkg::ZERO_WORD);
      pads();
      repeat (10)
      begin
         ext <= 8'($urandom);
         own <= 8'($urandom);
         poe <= 8'($urandom);
         pout <= 8'($urandom);
         areq <= 8'($urandom & $urandom);
         {dreg, dir, pull} = 24'($urandom);
         {slew, drv, an} = 24'($urandom & $urandom);
         bus(1'b1, pio_pkg::OFF_DATA, 32'(dreg));
         bus(1'b1, pio_pkg::OFF_DIR, 32'(dir));
         bus(1'b1, pio_pkg::OFF_PULL, 32'(pull));
         bus(1'b1, pio_pkg::OFF_SLEW, 32'(slew));
         bus(1'b1, pio_pkg::OFF_DRIVE, 32'(drv));
         bus(1'b1, pio_pkg::OFF_ANALOG, 32'(an));
         settle();
         rd(pio_pkg::OFF_DATA, exp_data());
         rd(pio_pkg::OFF_DIR, 32'(dir));
         rd(pio_pkg::OFF_PULL, 32'(pull));
         pads();
      end
      // input pins keep their latched value, shown once driven
      {own, areq} <= '0;
      an = 8'h00;
      dir = 8'hFF;
      bus(1'b1, pio_pkg::OFF_ANALOG, 32'(an));
      bus(1'b1, pio_pkg::OFF_DIR, 32'(dir));
      rd(pio_pkg::OFF_DATA, 32'(dreg));
      rd(8'h1C, pio_pkg::ZERO_WORD);
      // deep stop freezes latches, wake sets the flag
      deep_stop <= 1'b1;
      @(posedge hclk);
      // a peripheral grab while stopped must not reach the pads
      {own, poe, pout} <= {8'hFF, 8'h00, ~dreg};
      bus(1'b1, pio_pkg::OFF_DATA, 32'(~dreg));
      settle();
      check(32'(pin_out), 32'(dreg), "held pin_out");
      check(32'(pin_oe), 32'h0000_00FF, "held pin_oe");
      {deep_stop, own} <= {1'b0, 8'h00};
      deep_wake <= 1'b1;
      @(posedge hclk);
      deep_wake <= 1'b0;
      rd(pio_pkg::OFF_PWR, 32'(1) << pio_pkg::PWR_FLAG_BIT);
      bus(1'b1, pio_pkg::OFF_PWR, 32'(1) << pio_pkg::PWR_ACK_BIT);
      rd(pio_pkg::OFF_PWR, pio_pkg::ZERO_WORD);
      rd(pio_pkg::OFF_DATA, 32'(dreg));
      settle();
      check(32'(hresp), 32'(0), "hresp");
      print_verdict();
   end
endmodule
`default_nettype wire
